// ===== pkg/gpbc_pkg.sv
// Purpose: Shared constants and types for the change-detect GPIO port
// Assumes: Register port with one-cycle read latency
// Notes: Offsets are word indices on the plain register port
package gpbc_pkg;
  localparam int unsigned GPBC_W = 8;
  localparam int unsigned GPBC_AW = 4;
  localparam logic [3:0] GPBC_OFF_PIN_DATA = 4'h0;
  localparam logic [3:0] GPBC_OFF_DIRECTION = 4'h1;
  localparam logic [3:0] GPBC_OFF_LATCH = 4'h2;
  localparam logic [3:0] GPBC_OFF_IRQ_MAIN = 4'h3;
  localparam logic [3:0] GPBC_OFF_IRQ_TWO = 4'h4;
  localparam logic [3:0] GPBC_OFF_PERIPH = 4'h5;
  localparam int unsigned GPBC_BIT_CHANGE_FLAG = 0;
  localparam int unsigned GPBC_BIT_PULLUP_N = 7;
  localparam int unsigned GPBC_BIT_FAULT_EN = 0;
  localparam int unsigned GPBC_BIT_SHUT_TRI = 1;
  localparam int unsigned GPBC_PIN_UNIT2 = 3;
  localparam int unsigned GPBC_PIN_LVP = 5;
  localparam int unsigned GPBC_PIN_PCLK = 6;
  localparam int unsigned GPBC_PIN_PDAT = 7;
  localparam int unsigned GPBC_CHG_LO = 4;
  localparam logic [7:0] GPBC_RST_DIRECTION = 8'hff;
  localparam logic [7:0] GPBC_RST_LATCH = 8'h00;
  localparam logic [7:0] GPBC_RST_IRQ_TWO = 8'h80;
  localparam logic [7:0] GPBC_RST_PERIPH = 8'h00;

  typedef struct packed {
    logic [GPBC_AW-1:0] addr;
    logic [GPBC_W-1:0] wdata;
    logic wr;
    logic rd;
  } gpbc_req_t;

  typedef struct packed {
    logic alt_pin_sel_n;
    logic mcu_mode;
    logic pkg_80pin;
    logic lv_prog_cfg;
    logic serial_prog_en;
  } gpbc_cfg_t;

  typedef struct packed {
    logic cmp_out;
    logic cmp_oe;
    logic pwm_a_out;
    logic shutdown;
    logic capture_en;
  } gpbc_unit2_t;
endpackage : gpbc_pkg

// ===== core/gpbc_sync.sv
// Purpose: Two-flop synchroniser for a vector of pin levels
// Assumes: Single clock domain
// Notes: First stage is read only by the second
`timescale 1ns/100ps
`default_nettype none
module gpbc_sync #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      q_o <= '0;
    end else begin
      s1_q <= d_i;
      q_o <= s1_q;
    end
  end
endmodule : gpbc_sync
`default_nettype wire

// ===== core/gpbc_pin.sv
// Purpose: Output driver and pull-up selection for one port pin
// Assumes: Overrides are already resolved by the caller
// Notes: Purely combinational
`timescale 1ns/100ps
`default_nettype none
module gpbc_pin (
  // Control
  input wire logic dir_in_i,
  input wire logic latch_i,
  input wire logic ovr_en_i,
  input wire logic ovr_oe_i,
  input wire logic ovr_out_i,
  input wire logic pullup_n_i,
  input wire logic pu_block_i,
  // Pad side
  output logic out_o,
  output logic oe_o,
  output logic pu_o
);
  assign out_o = ovr_en_i ? ovr_out_i : latch_i;
  assign oe_o = ovr_en_i ? ovr_oe_i : !dir_in_i;
  assign pu_o = !pullup_n_i && !oe_o && !pu_block_i;
endmodule : gpbc_pin
`default_nettype wire

// ===== core/gpbc_port.sv
// Purpose: Eight-bit bidirectional port with change detection on the upper nibble
// Assumes: Pins synchronous enough for a two-flop synchroniser; register port strobes one cycle
// Notes: Registers reached by address index; read data valid one cycle after strobe
// Operation
// R01: Eight pins, each individually input or output.
// R02: Direction bit one makes the pin an input, driver off.
// R03: Direction bit zero drives the pin from its output latch.
// R04: Latch has own address; read back returns latch, not pins.
// R05: Writing the pin data register updates the output latch too.
// R06: Shared active-low pull-up enable at bit 7 of control two.
// R07: Pull-up forced off on any pin driven as output.
// R08: Pull-ups disabled after power-on reset.
// R09: Only upper four pins compare; outputs are excluded.
// R10: Inputs compared against snapshot from last pin data read.
// R11: Mismatches ORed into change flag at bit 0 of main control.
// R12: Set change flag drives a wake request.
// R13: Pin data access refreshes snapshot unless a move-class access.
// R14: Persisting mismatch keeps setting the change flag.
// R15: Software should not poll pin data during change detection.
// R16: Unit two uses pin 3 on 80-pin parts when remapped, not MCU mode.
// R17: Unit two output overrides latch on pin 3; input captures.
// R18: Channel A may tri-state during a PWM shutdown.
// R19: Pin 3 pull-up needs enable low and capture disabled.
// R20: Pins 0..3 feed external interrupts; pin 0 also fault input.
// R21: Low-voltage programming makes pin 5 entry input only.
// R22: Serial programming takes pin 6 clock and pin 7 data.
// R23: Pin data read returns synchronised pin levels; write updates latch.
// R24: Change flag sticky; clear ignored while mismatch persists.
`timescale 1ns/100ps
`default_nettype none
module gpbc_port
  import gpbc_pkg::*;
#(
  parameter int unsigned WIDTH = GPBC_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register port
  input wire gpbc_req_t req_i,
  input wire logic move_access_i,
  output logic [GPBC_W-1:0] rdata_o,
  // Device configuration and peripherals
  input wire gpbc_cfg_t cfg_i,
  input wire gpbc_unit2_t unit2_i,
  input wire logic prog_data_out_i,
  input wire logic prog_data_oe_i,
  // Pads
  input wire logic [GPBC_W-1:0] pin_i,
  output logic [GPBC_W-1:0] pin_o,
  output logic [GPBC_W-1:0] pin_oe_o,
  output logic [GPBC_W-1:0] pullup_o,
  // Peripheral inputs and status
  output logic [3:0] ext_irq_o,
  output logic pwm_fault_o,
  output logic unit2_capture_o,
  output logic lv_program_entry_o,
  output logic serial_prog_clock_o,
  output logic serial_prog_data_o,
  output logic change_flag_o,
  output logic wake_o
);
  if (WIDTH != GPBC_W) begin : g_width_check
    $error("gpbc_port supports only an eight-bit port");
  end

  logic [7:0] dir_q, dir_d;
  logic [7:0] lat_q, lat_d;
  logic [7:0] snap_q, snap_d;
  logic [7:0] ctl2_q, ctl2_d;
  logic [7:0] per_q, per_d;
  logic flag_q, flag_d;
  logic [7:0] rdata_q;
  logic [7:0] pin_oq, oe_oq, pu_oq;
  logic [3:0] ext_q;
  logic fault_q, cap_q, lvp_q, pclk_q, pdat_q, wake_q;
  logic [7:0] pin_s;
  logic [7:0] drv_out, drv_oe, drv_pu;
  logic [7:0] ovr_en, ovr_oe, ovr_out, pu_block;

  gpbc_sync #(.W(GPBC_W)) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(pin_i),
    .q_o(pin_s)
  );

  // Address decode
  wire sel_pd = (req_i.addr == GPBC_OFF_PIN_DATA);
  wire sel_dir = (req_i.addr == GPBC_OFF_DIRECTION);
  wire sel_lat = (req_i.addr == GPBC_OFF_LATCH);
  wire sel_im = (req_i.addr == GPBC_OFF_IRQ_MAIN);
  wire sel_i2 = (req_i.addr == GPBC_OFF_IRQ_TWO);
  wire sel_per = (req_i.addr == GPBC_OFF_PERIPH);
  wire wr_pd = req_i.wr && sel_pd;
  wire pd_touch = (req_i.wr || req_i.rd) && sel_pd && !move_access_i; // R13

  // Change detection on the upper nibble inputs only
  wire [3:0] chg_in = dir_q[7:GPBC_CHG_LO]; // R09
  wire [3:0] mism_v = (pin_s[7:GPBC_CHG_LO] ^ snap_q[7:GPBC_CHG_LO]) & chg_in; // R10
  wire mismatch = |mism_v; // R11
  wire flag_clr = req_i.wr && sel_im && !req_i.wdata[GPBC_BIT_CHANGE_FLAG];

  // Read mux
  wire [7:0] rd_mux = sel_pd ? pin_s : // R23
                      sel_dir ? dir_q :
                      sel_lat ? lat_q : // R04
                      sel_im ? {7'h00, flag_q} :
                      sel_i2 ? ctl2_q :
                      sel_per ? per_q : 8'h00;

  // Overrides
  wire unit2_here = cfg_i.pkg_80pin && !cfg_i.alt_pin_sel_n && !cfg_i.mcu_mode; // R16
  wire unit2_drv = unit2_here && !dir_q[GPBC_PIN_UNIT2] && unit2_i.cmp_oe; // R17
  wire shut_tri = per_q[GPBC_BIT_SHUT_TRI] && unit2_i.shutdown; // R18
  wire cap_on = unit2_here && dir_q[GPBC_PIN_UNIT2] && unit2_i.capture_en;

  always_comb begin
    ovr_en = 8'h00;
    ovr_oe = 8'h00;
    ovr_out = 8'h00;
    pu_block = 8'h00;
    if (unit2_drv) begin
      ovr_en[GPBC_PIN_UNIT2] = 1'b1; // R17
      ovr_oe[GPBC_PIN_UNIT2] = !shut_tri; // R18
      ovr_out[GPBC_PIN_UNIT2] = unit2_i.pwm_a_out | unit2_i.cmp_out;
    end
    pu_block[GPBC_PIN_UNIT2] = cap_on; // R19
    if (cfg_i.lv_prog_cfg) begin
      ovr_en[GPBC_PIN_LVP] = 1'b1; // R21
      pu_block[GPBC_PIN_LVP] = 1'b1;
    end
    if (cfg_i.serial_prog_en) begin
      ovr_en[GPBC_PIN_PCLK] = 1'b1; // R22
      pu_block[GPBC_PIN_PCLK] = 1'b1;
      ovr_en[GPBC_PIN_PDAT] = 1'b1;
      ovr_oe[GPBC_PIN_PDAT] = prog_data_oe_i;
      ovr_out[GPBC_PIN_PDAT] = prog_data_out_i;
      pu_block[GPBC_PIN_PDAT] = 1'b1;
    end
  end

  for (genvar i = 0; i < GPBC_W; i++) begin : g_pin
    gpbc_pin u_pin (
      .dir_in_i(dir_q[i]), // R02
      .latch_i(lat_q[i]), // R03
      .ovr_en_i(ovr_en[i]),
      .ovr_oe_i(ovr_oe[i]),
      .ovr_out_i(ovr_out[i]),
      .pullup_n_i(ctl2_q[GPBC_BIT_PULLUP_N]), // R06
      .pu_block_i(pu_block[i]),
      .out_o(drv_out[i]),
      .oe_o(drv_oe[i]), // R01
      .pu_o(drv_pu[i]) // R07
    );
  end

  // Next-state values
  assign dir_d = (req_i.wr && sel_dir) ? req_i.wdata : dir_q;
  assign lat_d = (req_i.wr && (sel_lat || sel_pd)) ? req_i.wdata : lat_q; // R05
  assign snap_d = pd_touch ? pin_s : snap_q; // R13
  assign ctl2_d = (req_i.wr && sel_i2) ? req_i.wdata : ctl2_q;
  assign per_d = (req_i.wr && sel_per) ? req_i.wdata : per_q;
  assign flag_d = mismatch ? 1'b1 : (flag_clr ? 1'b0 : flag_q); // R14 R24

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_q <= GPBC_RST_DIRECTION;
      lat_q <= GPBC_RST_LATCH;
      snap_q <= 8'h00;
      ctl2_q <= GPBC_RST_IRQ_TWO; // R08
      per_q <= GPBC_RST_PERIPH;
      flag_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      dir_q <= dir_d;
      lat_q <= lat_d;
      snap_q <= snap_d;
      ctl2_q <= ctl2_d;
      per_q <= per_d;
      flag_q <= flag_d;
      rdata_q <= req_i.rd ? rd_mux : 8'h00;
    end
  end

  // Pad and peripheral outputs registered so every output comes from a flop
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_oq <= 8'h00;
      oe_oq <= 8'h00;
      pu_oq <= 8'h00;
      ext_q <= 4'h0;
      fault_q <= 1'b0;
      cap_q <= 1'b0;
      lvp_q <= 1'b0;
      pclk_q <= 1'b0;
      pdat_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      pin_oq <= drv_out;
      oe_oq <= drv_oe;
      pu_oq <= drv_pu;
      ext_q <= pin_s[3:0] & dir_q[3:0]; // R20
      fault_q <= pin_s[0] && dir_q[0] && per_q[GPBC_BIT_FAULT_EN]; // R20
      cap_q <= cap_on && pin_s[GPBC_PIN_UNIT2]; // R17
      lvp_q <= cfg_i.lv_prog_cfg && pin_s[GPBC_PIN_LVP]; // R21
      pclk_q <= cfg_i.serial_prog_en && pin_s[GPBC_PIN_PCLK]; // R22
      pdat_q <= cfg_i.serial_prog_en && pin_s[GPBC_PIN_PDAT];
      wake_q <= flag_d; // R12
    end
  end

  assign rdata_o = rdata_q;
  assign pin_o = pin_oq;
  assign pin_oe_o = oe_oq;
  assign pullup_o = pu_oq;
  assign ext_irq_o = ext_q;
  assign pwm_fault_o = fault_q;
  assign unit2_capture_o = cap_q;
  assign lv_program_entry_o = lvp_q;
  assign serial_prog_clock_o = pclk_q;
  assign serial_prog_data_o = pdat_q;
  assign change_flag_o = flag_q;
  assign wake_o = wake_q;

  // Checks
  // Register port
  a_rdata_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R23
    !req_i.rd |=> (rdata_o == 8'h00))
    else $error("read data not zero outside a read");
  a_pd_read_pins: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R23
    (req_i.rd && sel_pd) |=> (rdata_o == $past(pin_s)))
    else $error("pin data read not from synchronised pins");
  a_lat_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R04
    (req_i.rd && sel_lat) |=> (rdata_o == $past(lat_q)))
    else $error("latch read not from latch");
  a_dir_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R01
    (req_i.rd && sel_dir) |=> (rdata_o == $past(dir_q)))
    else $error("direction read wrong");
  a_unmapped_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R04
    (req_i.rd && (req_i.addr > GPBC_OFF_PERIPH)) |=> (rdata_o == 8'h00))
    else $error("unmapped read not zero");
  a_pd_write_latch: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R05
    (req_i.wr && sel_pd) |=> (lat_q == $past(req_i.wdata)))
    else $error("pin data write missed latch");
  a_lat_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R04
    (req_i.wr && sel_lat) |=> (lat_q == $past(req_i.wdata)))
    else $error("latch write lost");
  a_dir_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R01
    (req_i.wr && sel_dir) |=> (dir_q == $past(req_i.wdata)))
    else $error("direction write lost");
  a_latch_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R04
    !(req_i.wr && (sel_pd || sel_lat)) |=> $stable(lat_q))
    else $error("latch changed without a write");

  // Change detection and flag
  a_flag_on_mismatch: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
    mismatch |=> flag_q)
    else $error("change flag not set on mismatch");
  a_flag_clr_blocked: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R24
    (flag_clr && mismatch) |=> flag_q)
    else $error("flag cleared during mismatch");
  a_flag_sticky: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R24
    (flag_q && !flag_clr) |=> flag_q)
    else $error("flag dropped without clear");
  a_flag_clear_ok: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R24
    (flag_clr && !mismatch) |=> !flag_q)
    else $error("flag clear ignored without mismatch");
  a_flag_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R11
    (!mismatch && !flag_q) |=> !flag_q)
    else $error("flag set without mismatch");
  a_snap_refresh: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R13
    pd_touch |=> (snap_q == $past(pin_s)))
    else $error("snapshot not refreshed");
  a_move_no_snap: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R13
    (move_access_i && sel_pd) |=> $stable(snap_q))
    else $error("move access changed snapshot");
  a_snap_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
    !pd_touch |=> $stable(snap_q))
    else $error("snapshot changed without access");
  a_low_nibble_out: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R09
    (pin_s[7:4] == snap_q[7:4]) |-> !mismatch)
    else $error("low nibble compared");
  a_outputs_excluded: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R09
    (dir_q[7:4] == 4'h0) |-> !mismatch)
    else $error("output pin compared");
  a_mismatch_seen: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R10
    ((dir_q[7:4] == 4'hf) && (pin_s[7:4] != snap_q[7:4])) |-> mismatch)
    else $error("input change not seen");
  a_touch_ends_mismatch: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R13
    pd_touch ##1 $stable(pin_s) |-> !mismatch)
    else $error("access did not end mismatch");
  a_wake_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R12
    1'b1 |=> (wake_o == flag_q))
    else $error("wake not tracking flag");
  a_wake_on_change: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R12
    mismatch |=> wake_o)
    else $error("no wake on mismatch");

  // Pads and pull-ups
  a_input_hiz: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R02
    (dir_q[0] && !cfg_i.serial_prog_en) |=> !pin_oe_o[0])
    else $error("input pin driven");
  a_output_latch: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R03
    !dir_q[1] |=> (pin_oe_o[1] && pin_o[1] == $past(lat_q[1])))
    else $error("output not from latch");
  a_pullup_off_out: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R07
    1'b1 |=> ((pullup_o & pin_oe_o) == 8'h00))
    else $error("pull-up on driven pin");
  a_pullup_needs_en: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R06
    ctl2_q[GPBC_BIT_PULLUP_N] |=> (pullup_o == 8'h00))
    else $error("pull-up on while disabled");
  a_pullup_inputs: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R06
    (!ctl2_q[GPBC_BIT_PULLUP_N] && dir_q[1]) |=> pullup_o[1])
    else $error("pull-up missing on input");
  a_pin3_capture_pu: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R19
    cap_on |=> !pullup_o[3])
    else $error("pull-up on capture input");
  a_unit2_prio: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R17
    (unit2_drv && !shut_tri && unit2_i.cmp_out) |=> (pin_oe_o[3] && pin_o[3]))
    else $error("unit two output lost priority");
  a_unit2_remote: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R16
    (!unit2_here && !dir_q[3]) |=> (pin_o[3] == $past(lat_q[3])))
    else $error("unit two drove an unmapped pin");
  a_shut_tri: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R18
    (unit2_drv && shut_tri) |=> !pin_oe_o[3])
    else $error("channel A driven during shutdown");
  a_lvp_no_drive: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R21
    cfg_i.lv_prog_cfg |=> (!pin_oe_o[5] && !pullup_o[5]))
    else $error("programming entry pin not released");
  a_prog_pins: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R22
    cfg_i.serial_prog_en |=> (!pin_oe_o[6] && !pullup_o[7]))
    else $error("serial programming pins not taken");

  // Peripheral inputs
  a_ext_irq_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R20
    (dir_q[3:0] == 4'h0) |=> (ext_irq_o == 4'h0))
    else $error("interrupt input from output pin");
  a_fault_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R20
    !per_q[GPBC_BIT_FAULT_EN] |=> !pwm_fault_o)
    else $error("fault input while disabled");
  a_lvp_entry: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R21
    !cfg_i.lv_prog_cfg |=> !lv_program_entry_o)
    else $error("programming entry while disabled");
endmodule : gpbc_port
`default_nettype wire

// ===== testbench/gpbc_board.sv
// Purpose: Board circuitry around the eight port pads
// Assumes: The port driver beats any board driver
// Notes: A pad nobody drives or pulls up toggles every cycle
`timescale 1ns/100ps
`default_nettype none
module gpbc_board (
  // Clock
  input wire logic mclk_i,
  // Port side of the pads
  input wire logic [7:0] port_out_i,
  input wire logic [7:0] port_oe_i,
  input wire logic [7:0] port_pu_i,
  // Board drivers
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] pad_o
);
  logic [7:0] flt_q = 8'h55;

  // Floating pads must not settle to a lucky constant
  always @(posedge mclk_i) begin
    flt_q <= ~flt_q;
  end
  for (genvar b = 0; b < 8; b++) begin : g_pad
    assign pad_o[b] = port_oe_i[b] ? port_out_i[b] : ext_en_i[b] ? ext_val_i[b] : port_pu_i[b] ? 1'b1 : flt_q[b];
  end
endmodule : gpbc_board
`default_nettype wire

// ===== testbench/gpbc_port_test.sv
// Purpose: Self-checking bench for the change-detect port
// Assumes: Board model resolves every pad
// Notes: Reads queue their expectation; a monitor checks rdata_o one cycle later
`timescale 1ns/100ps
`default_nettype none
module gpbc_port_test
  import gpbc_pkg::*;
;
  logic mclk_i = 0, rst_n_i = 0, move_access_i = 0, prog_data_out_i = 0, prog_data_oe_i = 0, rd_q = 0;
  gpbc_req_t req = '0;
  // Unit two remapped to pin 3 on an 80-pin part outside controller mode
  gpbc_cfg_t cfg = 5'h04;
  gpbc_unit2_t u2 = '0;
  logic [7:0] ext_en = 8'hff, ext_val = 8'h00, pin_i, pin_o, pin_oe_o, pullup_o, rdata_o, v, e;
  logic [3:0] ext_irq_o;
  logic pwm_fault_o, unit2_capture_o, lv_program_entry_o, serial_prog_clock_o, serial_prog_data_o;
  logic change_flag_o, wake_o;
  int mismatches = 0, tests_run = 0;
  logic [7:0] exp_q[$];

  always #4 mclk_i = ~mclk_i;

  gpbc_port gpbc_port_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req), .move_access_i(move_access_i),
    .rdata_o(rdata_o), .cfg_i(cfg), .unit2_i(u2), .prog_data_out_i(prog_data_out_i),
    .prog_data_oe_i(prog_data_oe_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pullup_o(pullup_o), .ext_irq_o(ext_irq_o), .pwm_fault_o(pwm_fault_o),
    .unit2_capture_o(unit2_capture_o), .lv_program_entry_o(lv_program_entry_o),
    .serial_prog_clock_o(serial_prog_clock_o), .serial_prog_data_o(serial_prog_data_o),
    .change_flag_o(change_flag_o), .wake_o(wake_o));

  gpbc_board gpbc_board_i (.mclk_i(mclk_i), .port_out_i(pin_o), .port_oe_i(pin_oe_o),
    .port_pu_i(pullup_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pin_i));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wt

  // One strobe cycle; for a read d is the expected data
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, input logic mv);
    @(posedge mclk_i);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    move_access_i <= mv;
    if (!w) exp_q.push_back(d);
    @(posedge mclk_i);
    req <= '0;
    move_access_i <= 1'b0;
  endtask : acc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] d);
    acc(1'b0, a, d, 1'b0);
  endtask : rd

  task automatic final_report;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge mclk_i) begin
    if (rd_q) chk(rdata_o, exp_q.pop_front());
    rd_q <= req.rd;
  end

  initial begin
    #200000;
    mismatches++;
    final_report();
  end

  initial begin
    v = 8'($urandom(32'hc663));
    e = 8'($urandom());
    wt(6);
    rst_n_i <= 1'b1;
    rd(GPBC_OFF_DIRECTION, GPBC_RST_DIRECTION);
    rd(GPBC_OFF_LATCH, GPBC_RST_LATCH);
    rd(GPBC_OFF_IRQ_TWO, GPBC_RST_IRQ_TWO);
    rd(GPBC_OFF_PERIPH, GPBC_RST_PERIPH);
    wr(4'h6, 8'h5a);
    rd(4'h6, 8'h00);
    chk(pullup_o, 8'h00);
    chk(pin_oe_o, 8'h00);
    wr(GPBC_OFF_IRQ_TWO, 8'h00);
    wt(3);
    chk(pullup_o, 8'hff);
    // Board lets go of every pad so only the pull-ups hold them
    ext_en <= 8'h00;
    wt(4);
    rd(GPBC_OFF_PIN_DATA, 8'hff);
    ext_en <= 8'hff;
    wr(GPBC_OFF_DIRECTION, 8'h0f);
    wt(3);
    chk(pullup_o, 8'h0f);
    u2.capture_en <= 1'b1;
    wt(4);
    chk(pullup_o, 8'h07);
    u2.capture_en <= 1'b0;
    wr(GPBC_OFF_LATCH, v);
    ext_val <= e;
    wt(4);
    chk(pin_oe_o, 8'hf0);
    chk(pin_o & 8'hf0, v & 8'hf0);
    rd(GPBC_OFF_LATCH, v);
    rd(GPBC_OFF_PIN_DATA, {v[7:4], e[3:0]});
    wr(GPBC_OFF_PIN_DATA, 8'h00);
    rd(GPBC_OFF_LATCH, 8'h00);
    wr(GPBC_OFF_DIRECTION, 8'hff);
    ext_val <= 8'h00;
    wt(4);
    rd(GPBC_OFF_PIN_DATA, 8'h00);
    wr(GPBC_OFF_IRQ_MAIN, 8'h00);
    wt(2);
    chk(8'(change_flag_o), 8'h00);
    ext_val <= 8'h20;
    wt(5);
    chk(8'(change_flag_o), 8'h01);
    chk(8'(wake_o), 8'h01);
    wr(GPBC_OFF_IRQ_MAIN, 8'h00);
    wt(2);
    chk(8'(change_flag_o), 8'h01);
    acc(1'b0, GPBC_OFF_PIN_DATA, 8'h20, 1'b1);
    wr(GPBC_OFF_IRQ_MAIN, 8'h00);
    wt(2);
    chk(8'(change_flag_o), 8'h01);
    rd(GPBC_OFF_PIN_DATA, 8'h20);
    wr(GPBC_OFF_IRQ_MAIN, 8'h00);
    wt(2);
    chk(8'(change_flag_o), 8'h00);
    ext_val <= 8'h2f;
    wt(5);
    chk(8'(change_flag_o), 8'h00);
    chk(8'(ext_irq_o), 8'h0f);
    wr(GPBC_OFF_DIRECTION, 8'h7f);
    wr(GPBC_OFF_LATCH, 8'h80);
    wt(5);
    chk(8'(change_flag_o), 8'h00);
    wr(GPBC_OFF_DIRECTION, 8'h00);
    wr(GPBC_OFF_LATCH, 8'h00);
    ext_val <= 8'hff;
    cfg.lv_prog_cfg <= 1'b1;
    cfg.serial_prog_en <= 1'b1;
    prog_data_oe_i <= 1'b1;
    prog_data_out_i <= 1'b1;
    u2.cmp_oe <= 1'b1;
    u2.cmp_out <= 1'b1;
    wt(5);
    chk(pin_oe_o, 8'h9f);
    chk(pin_o & 8'h88, 8'h88);
    chk(8'({lv_program_entry_o, serial_prog_clock_o, serial_prog_data_o}), 8'h07);
    cfg.mcu_mode <= 1'b1;
    wt(4);
    chk(8'(pin_o[3]), 8'h00);
    cfg.mcu_mode <= 1'b0;
    // Unit two keeps driving so the shutdown tri-state is visible
    u2.pwm_a_out <= 1'b1;
    u2.shutdown <= 1'b1;
    wr(GPBC_OFF_PERIPH, 8'h02);
    wt(3);
    chk(8'(pin_oe_o[3]), 8'h00);
    wr(GPBC_OFF_DIRECTION, 8'h09);
    wr(GPBC_OFF_PERIPH, 8'h01);
    u2.capture_en <= 1'b1;
    wt(4);
    chk(8'({unit2_capture_o, pwm_fault_o}), 8'h03);
    // Reset in mid-run must bring every output and control back
    rst_n_i <= 1'b0;
    wt(2);
    chk(8'({change_flag_o, wake_o, pwm_fault_o}), 8'h00);
    chk(pullup_o | pin_oe_o, 8'h00);
    rst_n_i <= 1'b1;
    rd(GPBC_OFF_IRQ_TWO, GPBC_RST_IRQ_TWO);
    wt(2);
    final_report();
  end
endmodule : gpbc_port_test
`default_nettype wire
